// ===== acces_map.svh
// Register offsets, field positions and reset values of the clock config/error bank
// Assumes 8-bit register addresses from the device control interface
`ifndef ACCES_MAP_SVH
`define ACCES_MAP_SVH
`define ACCES_ADDR_FSYNC_CFG   8'h3A
`define ACCES_ADDR_RATIO_LOW   8'h3B
`define ACCES_ADDR_ERR_FIRST   8'h3C
`define ACCES_ADDR_ERR_SECOND  8'h3D
`define ACCES_RST_BYTE         8'h00
`define ACCES_BIT_INT_BCLK     7
`define ACCES_BIT_INV_BCLK     6
`define ACCES_RATIO_UP_MSB     5
`define ACCES_ERR0_DSP         7
`define ACCES_ERR0_SRC         4
`define ACCES_ERR0_DEM         3
`define ACCES_ERR0_PDM         2
`define ACCES_ERR0_STOP        1
`define ACCES_ERR1_PBCLK       7
`define ACCES_ERR1_SBCLK       6
`define ACCES_ERR1_CONTROLLER_REFERENCE_CLOCK        5
`define ACCES_ERR1_PFS         4
`define ACCES_ERR1_SFS         3
`define ACCES_STOP_TIME_US     1000
`define ACCES_CLK_MHZ          20
`define ACCES_STOP_CYCLES      (`ACCES_STOP_TIME_US * `ACCES_CLK_MHZ)
`endif

// ===== acces_pkg.sv
// Types shared by the clock config and error status bank
// Assumes acces_map.svh supplies the numeric constants
package acces_pkg;
   typedef struct packed {
      logic       dsp_clock_ratio_error;
      logic       rate_converter_ratio_error;
      logic       modulator_rate_error;
      logic       pdm_clock_error;
      logic       audio_clock_stopped;
      logic       primary_bclk_ratio_error;
      logic       secondary_bclk_ratio_error;
      logic       controller_clock_ratio_error;
      logic       primary_frame_error;
      logic       secondary_frame_error;
   } acces_mon_s;

   typedef struct packed {
      logic       gen_enable;
      logic       bclk_internal;
      logic       bclk_invert;
      logic [13:0] ratio;
   } acces_fsync_s;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } acces_req_s;
endpackage

// ===== acces_stop_timer.sv
// Stop detector: flags an audio clock that has been idle for a full interval
// Assumes clock_active is already synchronised to clk
`timescale 1ns/10ps
`include "acces_map.svh"
module acces_stop_timer
   import acces_pkg::*;
#(
   parameter int STOP_CYCLES = `ACCES_STOP_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clock_active,
   output logic      stopped
);
   typedef struct packed {
      logic [31:0] count;
      logic        stopped;
   } acces_tmr_s;

   acces_tmr_s st_q;
   acces_tmr_s st_d;

   always_comb begin
      st_d = st_q;
      if (clock_active) begin
         st_d.count   = '0;
         st_d.stopped = 1'b0;
      end else if (st_q.count >= 32'(STOP_CYCLES - 1)) begin
         st_d.stopped = 1'b1;
      end else begin
         st_d.count = st_q.count + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign stopped = st_q.stopped;
endmodule

// ===== acces_bank.sv
// Secondary-port frame-sync settings and clock error status registers
// Assumes a byte register port from the control interface, same clock domain,
// and monitor levels from asynchronous clock checkers (synchronised here).
`timescale 1ns/10ps
`include "acces_map.svh"
module acces_bank
   import acces_pkg::*;
#(
   parameter int STOP_CYCLES = `ACCES_STOP_CYCLES
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire acces_req_s   req,
   input  wire logic         secondary_controller_select,
   input  wire logic         custom_ratio_mode,
   input  wire logic         audio_clock_active,
   input  wire acces_mon_s   mon,
   output logic [7:0]        rdata,
   output logic              rvalid,
   output acces_fsync_s      fsync_cfg
);
   typedef struct packed {
      logic [1:0]  ctl_sync1;
      logic [1:0]  ctl_sync2;
      acces_mon_s  mon_sync1;
      acces_mon_s  mon_sync2;
      logic [7:0]  cfg5;
      logic [7:0]  cfg6;
      logic [7:0]  err0;
      logic [7:0]  err1;
      logic [7:0]  rdata;
      logic        rvalid;
      acces_fsync_s fsync;
   } acces_state_s;

   acces_state_s st_q;
   acces_state_s st_d;
   logic         stopped;

   // ------------------------------------------------------------
   // Clock stop timer
   // ------------------------------------------------------------
   acces_stop_timer #(
      .STOP_CYCLES (STOP_CYCLES)
   ) u_stop (
      .clk          (clk),
      .rst_n        (rst_n),
      .clock_active (st_q.ctl_sync2[1]),
      .stopped      (stopped)
   );

   function automatic logic [7:0] acces_read(input acces_state_s s, input logic [7:0] a);
      logic [7:0] v;
      v = `ACCES_RST_BYTE;
      unique case (a)
         `ACCES_ADDR_FSYNC_CFG:  v = s.cfg5;
         `ACCES_ADDR_RATIO_LOW:  v = s.cfg6;
         `ACCES_ADDR_ERR_FIRST:  v = s.err0;
         `ACCES_ADDR_ERR_SECOND: v = s.err1;
         default:                v = `ACCES_RST_BYTE;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Monitors come from other clock domains
      st_d.ctl_sync1 = {audio_clock_active, custom_ratio_mode};
      st_d.ctl_sync2 = st_q.ctl_sync1;
      st_d.mon_sync1 = mon;
      st_d.mon_sync2 = st_q.mon_sync1;

      if (req.write) begin
         if (req.addr == `ACCES_ADDR_FSYNC_CFG) begin
            st_d.cfg5 = req.wdata;
         end
         if (req.addr == `ACCES_ADDR_RATIO_LOW) begin
            st_d.cfg6 = req.wdata;
         end
         // Status addresses take no write; flags follow monitors, custom_ratio_mode and the stop timer only
      end

      // Level flags track live conditions, reserved bits stay zero
      st_d.err0 = `ACCES_RST_BYTE;
      st_d.err0[`ACCES_ERR0_DSP]  = st_q.mon_sync2.dsp_clock_ratio_error;
      st_d.err0[`ACCES_ERR0_SRC]  = st_q.mon_sync2.rate_converter_ratio_error
                                    & ~st_q.ctl_sync2[0];
      st_d.err0[`ACCES_ERR0_DEM]  = st_q.mon_sync2.modulator_rate_error;
      st_d.err0[`ACCES_ERR0_PDM]  = st_q.mon_sync2.pdm_clock_error;
      st_d.err0[`ACCES_ERR0_STOP] = stopped | st_q.mon_sync2.audio_clock_stopped;
      st_d.err1 = `ACCES_RST_BYTE;
      st_d.err1[`ACCES_ERR1_PBCLK] = st_q.mon_sync2.primary_bclk_ratio_error;
      st_d.err1[`ACCES_ERR1_SBCLK] = st_q.mon_sync2.secondary_bclk_ratio_error;
      st_d.err1[`ACCES_ERR1_CONTROLLER_REFERENCE_CLOCK]  = st_q.mon_sync2.controller_clock_ratio_error;
      st_d.err1[`ACCES_ERR1_PFS]   = st_q.mon_sync2.primary_frame_error;
      st_d.err1[`ACCES_ERR1_SFS]   = st_q.mon_sync2.secondary_frame_error;

      st_d.rvalid = req.read;
      st_d.rdata  = req.read ? acces_read(st_q, req.addr) : `ACCES_RST_BYTE;

      // Settings reach the generator only in controller configuration
      st_d.fsync.gen_enable    = secondary_controller_select;
      st_d.fsync.bclk_internal = secondary_controller_select & st_q.cfg5[`ACCES_BIT_INT_BCLK];
      st_d.fsync.bclk_invert   = secondary_controller_select & st_q.cfg5[`ACCES_BIT_INV_BCLK];
      st_d.fsync.ratio         = secondary_controller_select ?
                                 {st_q.cfg5[`ACCES_RATIO_UP_MSB:0], st_q.cfg6} : 14'h0000;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata     = st_q.rdata;
   assign rvalid    = st_q.rvalid;
   assign fsync_cfg = st_q.fsync;
endmodule

// ===== acces_bank_monitor.sv
// Checker for the clock config and error status bank
// Assumes it is bound onto acces_bank and sees only its ports
`timescale 1ns/10ps
`include "acces_map.svh"
module acces_bank_monitor
   import acces_pkg::*;
#(
   parameter int STOP_CYCLES = `ACCES_STOP_CYCLES
) (
   input wire logic         clk,
   input wire logic         rst_n,
   input wire acces_req_s   req,
   input wire logic         secondary_controller_select,
   input wire logic         custom_ratio_mode,
   input wire logic         audio_clock_active,
   input wire acces_mon_s   mon,
   input wire logic [7:0]   rdata,
   input wire logic         rvalid,
   input wire acces_fsync_s fsync_cfg
);
   logic [15:0] idle_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         idle_q <= '0;
      else if (audio_clock_active)
         idle_q <= '0;
      else if (idle_q < 16'hFFFF)
         idle_q <= idle_q + 16'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Monitors steady long enough to have crossed the synchronisers
   sequence s_ans(logic [7:0] a);
      $stable({mon, custom_ratio_mode})[*5] ##0 rvalid && $past(req.addr) == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      secondary_controller_select && req.write && req.addr == a ##1 secondary_controller_select[*2];
   endsequence
   property p_rvalid;
      1'b1 |=> rvalid == $past(req.read) && (rvalid || rdata == 8'h00);
   endproperty
   property p_sts0;
      s_ans(8'h3C) |-> {rdata[7:2], rdata[0]} == {mon[9], 2'b00, mon[8] && !custom_ratio_mode, mon[7:6], 1'b0};
   endproperty
   property p_sts1;
      s_ans(8'h3D) |-> rdata == {mon[4:0], 3'b000};
   endproperty
   property p_unmapped;
      rvalid && ($past(req.addr) < 8'h3A || $past(req.addr) > 8'h3D) |-> rdata == 8'h00;
   endproperty
   property p_tgt;
      !secondary_controller_select[*2] |-> fsync_cfg == '0;
   endproperty
   property p_cfg_hi;
      s_wr(8'h3A) |-> fsync_cfg.gen_enable && fsync_cfg[15:8] == $past(req.wdata, 2);
   endproperty
   property p_cfg_lo;
      s_wr(8'h3B) |-> fsync_cfg.ratio[7:0] == $past(req.wdata, 2);
   endproperty
   property p_stop;
      idle_q > STOP_CYCLES + 5 && rvalid && $past(req.addr) == 8'h3C |-> rdata[1];
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
   a_sts0: assert property (p_sts0) else $error("first status wrong");
   a_sts1: assert property (p_sts1) else $error("second status wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_tgt: assert property (p_tgt) else $error("settings leak in target mode");
   a_cfg_hi: assert property (p_cfg_hi) else $error("upper settings wrong");
   a_cfg_lo: assert property (p_cfg_lo) else $error("lower ratio wrong");
   a_stop: assert property (p_stop) else $error("stop flag missing");
endmodule
bind acces_bank acces_bank_monitor #(.STOP_CYCLES(STOP_CYCLES)) u_mon (.clk, .rst_n, .req,
   .secondary_controller_select, .custom_ratio_mode, .audio_clock_active, .mon, .rdata, .rvalid, .fsync_cfg);

// ===== acces_host_model.sv
// Host side of the control interface: one-cycle register strobes
// Assumes rdata/rvalid answer one cycle after the read edge
`timescale 1ns/10ps
module acces_host_model
   import acces_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output acces_req_s      req
);
   initial req = '0;
   // Idle lines carry inverted values so stale data cannot pass
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1 r = {rvalid, rdata};
   endtask
endmodule

// ===== acces_bank_tb_top.sv
// Self-checking bench for the clock config and error status bank
// Assumes a short stop interval of 16 cycles
`timescale 1ns/10ps
module acces_bank_tb_top
   import acces_pkg::*;
;
   logic         clk, rst_n, sel, custom, active, rvalid;
   logic [7:0]   rdata;
   logic [8:0]   r;
   acces_req_s   req;
   acces_mon_s   mon;
   acces_fsync_s cfg;
   int           n_fail, checks, cyc;
   acces_bank #(.STOP_CYCLES(16)) uut (.clk(clk), .rst_n(rst_n), .req(req), .secondary_controller_select(sel),
      .custom_ratio_mode(custom), .audio_clock_active(active), .mon(mon), .rdata(rdata), .rvalid(rvalid),
      .fsync_cfg(cfg));
   acces_host_model u_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task final_report;
      if (n_fail == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [23:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rdc(input logic [7:0] a, exp);
      u_host.rd(a, r);
      chk(24'(r), {16'h0001, exp});
   endtask
   task t_cfg;
      @(posedge clk) sel <= 1'b1;
      u_host.wr(8'h3A, 8'hC5);
      u_host.wr(8'h3B, 8'hA3);
      rdc(8'h3B, 8'hA3);
      chk(24'(cfg), 24'h01C5A3);
      u_host.wr(8'h3A, 8'h7F);
      rdc(8'h3A, 8'h7F);
      chk(24'(cfg), 24'h017FA3);
      u_host.wr(8'h3A, 8'h80);
      rdc(8'h3A, 8'h80);
      chk(24'(cfg), 24'h0180A3);
      @(posedge clk) sel <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(24'(cfg), 24'h000000);
   endtask
   task t_flags;
      logic [9:0] m;
      for (int i = 0; i < 10; i++) begin
         m = 10'h001 << i;
         @(posedge clk) mon <= m;
         repeat (4) @(posedge clk);
         rdc(8'h3C, {m[9], 2'b00, m[8:5], 1'b0});
         rdc(8'h3D, {m[4:0], 3'b000});
      end
      @(posedge clk) custom <= 1'b1;
      mon <= '1;
      repeat (4) @(posedge clk);
      rdc(8'h3C, 8'h8E);
      @(posedge clk) mon <= '0;
      repeat (4) @(posedge clk);
      u_host.wr(8'h3C, 8'h9E);
      u_host.wr(8'h3D, 8'hF8);
      u_host.wr(8'h40, 8'hFF);
      rdc(8'h3C, 8'h00);
      rdc(8'h3D, 8'h00);
      rdc(8'h40, 8'h00);
   endtask
   task t_stop;
      @(posedge clk) active <= 1'b0;
      repeat (24) @(posedge clk);
      rdc(8'h3C, 8'h02);
      @(posedge clk) active <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(8'h3C, 8'h00);
   endtask
   task t_reset;
      @(posedge clk) mon <= '1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h3C, 8'h00);
      rdc(8'h3D, 8'hF8);
      rdc(8'h3C, 8'h8E);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      {rst_n, sel, custom, active, mon} = {4'b0001, 10'h000};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 8'h3A; a <= 8'h3D; a++)
         rdc(8'(a), 8'h00);
      t_cfg;
      t_flags;
      t_stop;
      t_reset;
      final_report;
   end
endmodule
